/* File: inc/flash_sp_cfg.svh */
// constants for the flash self-programming sequencer
`ifndef FLASH_SP_CFG_SVH
`define FLASH_SP_CFG_SVH
`define CLK_PERIOD_NS 4
`define OP_MIN_US 3700
`define OP_MAX_US 4500
`define OP_CYCLES ((`OP_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ARM_WINDOW 4
`define PAGE_WORDS 64
`define RW_REGION_LAST 15'h47ff
`define BOOT_START_11 15'h4f00
`define BOOT_START_10 15'h4e00
`define BOOT_START_01 15'h4c00
`define BOOT_START_00 15'h4800
`define CR_ENABLE 0
`define CR_ERASE 1
`define CR_WRITE 2
`define CR_REENABLE 4
`define CR_BUSY 6
`define REG_CTRL 2'h0
`define REG_STAT 2'h1
`define REG_MASK 2'h2
`define REG_ZPTR 2'h3
`endif

/* File: inc/flash_sp_pkg.sv */
// types for the flash self-programming sequencer
package flash_sp_pkg;
   typedef enum logic [1:0] {CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_REENABLE} cmd_t;
   typedef logic [15:0] word_t;
   typedef logic [14:0] waddr_t;
endpackage

/* File: inc/flash_sp_if.sv */
// link between the CPU side and the self-programming sequencer
`timescale 1ns/1ns
interface flash_sp_if;
   logic [7:0] ctrl_wdata; // control register write data
   logic ctrl_we; // control register write pulse
   logic [7:0] ctrl_rdata; // control register contents
   logic spm_exec; // store instruction pulse
   logic [15:0] zptr; // pointer register
   logic [15:0] r1r0; // data register pair
   logic eeprom_write_active; // eeprom write in progress
   logic [14:0] fetch_addr; // instruction fetch word address
   logic fetch_block; // fetch would hit busy region
   modport dev (input ctrl_wdata, ctrl_we, spm_exec, zptr, r1r0, eeprom_write_active, fetch_addr,
                output ctrl_rdata, fetch_block);
   modport cpu (output ctrl_wdata, ctrl_we, spm_exec, zptr, r1r0, eeprom_write_active, fetch_addr,
                input ctrl_rdata, fetch_block);
endinterface

/* File: design/flash_sp_dev.sv */
// self-programming sequencer: control register, page buffer, timed flash operations
`timescale 1ns/1ns
`include "flash_sp_cfg.svh"
module flash_sp_dev
   import flash_sp_pkg::*;
(
   input wire logic CLK_SYS, // system clock
   input wire logic RST, // synchronous reset
   flash_sp_if.dev LINK, // cpu side
   input wire logic [1:0] BOOT_SIZE_SEL, // boot size fuses, hi/lo
   output logic [14:0] BOOT_RESET_ADDR, // boot section start
   output logic FLASH_ERASE, // page erase pulse
   output logic FLASH_WRITE, // page write pulse
   output logic [6:0] PAGE_INDEX, // page for erase/write
   output logic [1023:0] PAGE_BUF, // temporary page buffer
   output logic RW_REGION_BUSY // readable region not readable
);
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} state_t;
   typedef struct packed {
      state_t st;
      logic [2:0] arm_cnt;
      logic [23:0] op_cnt;
      cmd_t cmd;
      logic enable;
      logic busy;
      logic erase;
      logic write;
      logic [6:0] page;
      logic [1023:0] buf_data;
      logic [14:0] boot_addr;
      logic block;
   } dev_state_t;
   dev_state_t s, next_s;

   localparam logic [23:0] OP_CYC = 24'(`OP_CYCLES);

   // decode the command bits of a control write
   function automatic cmd_t decode(input logic [7:0] v);
      if (v[`CR_ERASE]) decode = CMD_ERASE;
      else if (v[`CR_WRITE]) decode = CMD_WRITE;
      else if (v[`CR_REENABLE]) decode = CMD_REENABLE;
      else decode = CMD_FILL;
   endfunction

   // boot start from fuse pair
   function automatic logic [14:0] boot_start(input logic [1:0] f);
      case (f)
         2'h3: boot_start = `BOOT_START_11;
         2'h2: boot_start = `BOOT_START_10;
         2'h1: boot_start = `BOOT_START_01;
         default: boot_start = `BOOT_START_00;
      endcase
   endfunction

   // sequencer
   always_comb begin
      next_s = s;
      next_s.erase = 1'b0;
      next_s.write = 1'b0;
      next_s.boot_addr = boot_start(BOOT_SIZE_SEL);
      // fetches into the readable region stall while busy; boot code sits above it
      next_s.block = s.busy && (LINK.fetch_addr <= `RW_REGION_LAST);
      case (s.st)
         ST_IDLE: begin
            // writes refused while an eeprom write is active
            if (LINK.ctrl_we && LINK.ctrl_wdata[`CR_ENABLE] && !LINK.eeprom_write_active) begin
               next_s.st = ST_ARMED;
               next_s.enable = 1'b1;
               next_s.cmd = decode(LINK.ctrl_wdata);
               next_s.arm_cnt = 3'h0;
            end
         end
         ST_ARMED: begin
            if (LINK.spm_exec) begin
               next_s.page = LINK.zptr[13:7];
               case (s.cmd)
                  CMD_FILL: begin
                     next_s.buf_data[LINK.zptr[6:1]*16 +: 16] = LINK.r1r0;
                     next_s.enable = 1'b0;
                     next_s.st = ST_IDLE;
                  end
                  CMD_REENABLE: begin
                     next_s.busy = 1'b0;
                     next_s.enable = 1'b0;
                     next_s.st = ST_IDLE;
                  end
                  CMD_ERASE: begin
                     next_s.erase = 1'b1;
                     next_s.busy = 1'b1;
                     next_s.op_cnt = OP_CYC;
                     next_s.st = ST_BUSY;
                  end
                  default: begin
                     next_s.write = 1'b1;
                     next_s.busy = 1'b1;
                     next_s.op_cnt = OP_CYC;
                     next_s.st = ST_BUSY;
                  end
               endcase
            end else if (s.arm_cnt == 3'(`ARM_WINDOW - 1)) begin
               next_s.enable = 1'b0; // window expired
               next_s.st = ST_IDLE;
            end else begin
               next_s.arm_cnt = s.arm_cnt + 3'h1;
            end
         end
         ST_BUSY: begin
            if (s.op_cnt <= 24'h1) begin
               next_s.enable = 1'b0;
               next_s.st = ST_IDLE;
            end else begin
               next_s.op_cnt = s.op_cnt - 24'h1;
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign LINK.ctrl_rdata = {1'b0, s.busy, 3'h0, s.cmd == CMD_WRITE && s.enable,
                             s.cmd == CMD_ERASE && s.enable, s.enable};
   assign LINK.fetch_block = s.block;
   assign BOOT_RESET_ADDR = s.boot_addr;
   assign FLASH_ERASE = s.erase;
   assign FLASH_WRITE = s.write;
   assign PAGE_INDEX = s.page;
   assign PAGE_BUF = s.buf_data;
   assign RW_REGION_BUSY = s.busy;
endmodule // flash_sp_dev

/* File: design/flash_sp_cpu.sv */
// cpu-side driver of the self-programming link, with status and interrupt registers
`timescale 1ns/1ns
`include "flash_sp_cfg.svh"
module flash_sp_cpu
   import flash_sp_pkg::*;
(
   input wire logic CLK_SYS, // system clock
   input wire logic RST, // synchronous reset
   flash_sp_if.cpu LINK, // to sequencer
   input wire logic [1:0] ADDR, // register address
   input wire logic [15:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [15:0] RDATA, // read data, next cycle
   output logic IRQ, // level interrupt
   input wire logic EE_ACTIVE, // eeprom write flag
   input wire logic [14:0] FETCH_ADDR // current fetch address
);
   typedef enum logic [1:0] {C_IDLE, C_WAIT, C_ARM, C_EXEC} cstate_t;
   typedef struct packed {
      cstate_t st;
      logic [7:0] cmd;
      logic [15:0] data;
      logic [15:0] z;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [15:0] rdata;
      logic irq;
      logic we;
      logic exec;
      logic prev_enable;
   } cpu_state_t;
   cpu_state_t s, next_s;

   // sequence one command; status bit0 done, bit1 refused
   always_comb begin
      next_s = s;
      next_s.we = 1'b0;
      next_s.exec = 1'b0;
      next_s.rdata = 16'h0000;
      next_s.prev_enable = LINK.ctrl_rdata[`CR_ENABLE];
      if (RD) begin
         case (ADDR)
            `REG_CTRL: next_s.rdata = {8'h00, LINK.ctrl_rdata};
            `REG_STAT: next_s.rdata = {14'h0000, s.stat};
            `REG_MASK: next_s.rdata = {14'h0000, s.mask};
            default: next_s.rdata = s.z;
         endcase
      end
      if (WR) begin
         case (ADDR)
            `REG_STAT: next_s.stat = s.stat & ~WDATA[1:0];
            `REG_MASK: next_s.mask = WDATA[1:0];
            `REG_ZPTR: next_s.z = {WDATA[15:1], 1'b0};
            default: if (s.st == C_IDLE) begin
               next_s.cmd = WDATA[7:0];
               next_s.data = {8'h00, WDATA[15:8]}; // high byte carries the low byte of the fill word; its upper byte is zero
               next_s.st = C_WAIT;
            end
         endcase
      end
      case (s.st)
         C_WAIT: if (!LINK.ctrl_rdata[`CR_ENABLE] && !EE_ACTIVE) next_s.st = C_ARM;
         C_ARM: begin
            next_s.we = 1'b1;
            next_s.st = C_EXEC;
         end
         C_EXEC: begin
            next_s.exec = 1'b1; // one cycle after the write
            if (s.cmd[`CR_WRITE]) next_s.z = {s.z[15:7], 7'h00};
            next_s.st = C_IDLE;
         end
         default: ;
      endcase
      // set wins over a same-cycle clear
      if (s.prev_enable && !LINK.ctrl_rdata[`CR_ENABLE]) next_s.stat[0] = 1'b1;
      // the sequencer arms one cycle after the write, so judge it at the store pulse
      if (s.exec && !LINK.ctrl_rdata[`CR_ENABLE]) next_s.stat[1] = 1'b1;
      next_s.irq = |(next_s.stat & next_s.mask);
   end

   // state register
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign LINK.ctrl_wdata = s.cmd | 8'h01;
   assign LINK.ctrl_we = s.we;
   assign LINK.spm_exec = s.exec;
   assign LINK.zptr = s.z;
   assign LINK.r1r0 = s.data;
   assign LINK.eeprom_write_active = EE_ACTIVE;
   assign LINK.fetch_addr = FETCH_ADDR;
   assign RDATA = s.rdata;
   assign IRQ = s.irq;
endmodule // flash_sp_cpu

/* File: test/flash_sp_asserts.sv */
// concurrent checks on the self-programming link between cpu side and sequencer
`timescale 1ns/1ns
`include "flash_sp_cfg.svh"
module flash_sp_asserts (
   input wire logic CLK_SYS, // system clock
   input wire logic RST, // synchronous reset
   input wire logic [7:0] ctrl_wdata, // command byte
   input wire logic ctrl_we, // command write pulse
   input wire logic [7:0] ctrl_rdata, // control contents
   input wire logic spm_exec, // store pulse
   input wire logic [15:0] zptr, // pointer
   input wire logic eeprom_write_active, // eeprom busy
   input wire logic [14:0] fetch_addr, // fetch address
   input wire logic fetch_block // fetch stall
);
   logic long_op;
   logic [20:0] op_cnt;
   logic reen_seen;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // length of a timed operation, and whether a re-enable was ordered
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         long_op <= 1'b0;
         op_cnt <= 21'h0;
         reen_seen <= 1'b0;
      end else begin
         if (spm_exec && (ctrl_rdata[1] || ctrl_rdata[2])) begin
            long_op <= 1'b1;
            op_cnt <= 21'h0;
         end else if (!ctrl_rdata[0]) begin
            long_op <= 1'b0;
         end else begin
            op_cnt <= op_cnt + 21'h1;
         end
         if (ctrl_we && ctrl_wdata[4] && ctrl_wdata[0]) begin
            reen_seen <= 1'b1;
         end else if ($rose(ctrl_rdata[6])) begin
            reen_seen <= 1'b0;
         end
      end
   end
   AST_FILL_DONE: assert property (spm_exec && ctrl_rdata[0] && ctrl_rdata[2:1] == 2'h0 && !ctrl_rdata[4]
      |-> ##[1:2] !ctrl_rdata[0]) else $error("fill did not release enable");
   AST_LONG_BUSY: assert property (spm_exec && (ctrl_rdata[1] || ctrl_rdata[2])
      |-> ##[1:3] (ctrl_rdata[6] && ctrl_rdata[0])) else $error("busy not raised by flash operation");
   AST_OP_TIME: assert property ($fell(ctrl_rdata[0]) && long_op
      |-> op_cnt >= `OP_CYCLES - 2 && op_cnt <= 1125000) else $error("flash operation length out of range");
   AST_BUSY_KEEP: assert property ($fell(ctrl_rdata[6]) |-> reen_seen) else $error("busy dropped unasked");
   AST_EE_ARM: assert property (eeprom_write_active && !ctrl_rdata[0]
      |=> !ctrl_rdata[0]) else $error("armed during eeprom write");
   AST_EXEC_WINDOW: assert property ($rose(ctrl_rdata[0]) |-> ##[0:4] spm_exec) else $error("store late");
   AST_Z0_ZERO: assert property (spm_exec |-> !zptr[0]) else $error("pointer bit zero set on store");
   AST_POLL: assert property (ctrl_we |-> !ctrl_rdata[0]) else $error("command while enable set");
   AST_FETCH_BLK: assert property (ctrl_rdata[6] && fetch_addr <= `RW_REGION_LAST
      |-> ##[0:1] fetch_block) else $error("busy region fetch not blocked");
   AST_FETCH_FREE: assert property ((fetch_addr > `RW_REGION_LAST)[*2] |-> !fetch_block) else $error("boot fetch blocked");
   AST_WRITE_WORD0: assert property (spm_exec && ctrl_rdata[2] |-> zptr[6:1] == 6'h00)
      else $error("page write with word bits set");
   // main scenarios reached
   cover property (spm_exec && ctrl_rdata[2:0] == 3'h1);
   cover property (spm_exec && ctrl_rdata[1]);
   cover property (spm_exec && ctrl_rdata[2]);
endmodule // flash_sp_asserts

/* File: test/tb.sv */
// self-checking bench joining the cpu side and the sequencer
`timescale 1ns/1ns
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic irq;
   logic ee_active = 1'b0;
   logic [14:0] fetch_addr = 15'h4800;
   logic [1:0] boot_sel = 2'h0;
   logic [14:0] boot_addr;
   logic flash_erase;
   logic flash_write;
   logic [6:0] page_index;
   logic rw_busy;
   logic [1023:0] page_buf;
   logic [15:0] d;
   logic [14:0] boot_tab [4];
   int n_errors = 0;
   int comparisons = 0;
   flash_sp_if link();
   flash_sp_dev flash_sp_dev_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(link.dev), .BOOT_SIZE_SEL(boot_sel),
      .BOOT_RESET_ADDR(boot_addr), .FLASH_ERASE(flash_erase), .FLASH_WRITE(flash_write),
      .PAGE_INDEX(page_index), .PAGE_BUF(page_buf), .RW_REGION_BUSY(rw_busy));
   flash_sp_cpu flash_sp_cpu_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(link.cpu), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .EE_ACTIVE(ee_active), .FETCH_ADDR(fetch_addr));
   flash_sp_asserts flash_sp_asserts_i (.CLK_SYS(clk_sys), .RST(rst), .ctrl_wdata(link.ctrl_wdata),
      .ctrl_we(link.ctrl_we), .ctrl_rdata(link.ctrl_rdata), .spm_exec(link.spm_exec), .zptr(link.zptr),
      .eeprom_write_active(link.eeprom_write_active), .fetch_addr(link.fetch_addr),
      .fetch_block(link.fetch_block));
   // 4 ns clock
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [1:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample mid-cycle
   task rd_reg(input logic [1:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask
   task reset_dut();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
   endtask
   task test_boot();
      boot_tab = '{15'h4800, 15'h4c00, 15'h4e00, 15'h4f00};
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys) boot_sel <= k[1:0];
         reset_dut();
         repeat (2) @(negedge clk_sys);
         chk(boot_addr, boot_tab[k]);
      end
   endtask
   // buffer fill with the done event masked in, then masked out
   task test_fill_irq();
      wr_reg(2'h2, 16'h0001);
      wr_reg(2'h3, 16'h0004);
      wr_reg(2'h0, 16'ha501);
      for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clk_sys);
      chk(irq, 1'b1);
      chk(page_buf[47:32], 16'h00a5);
      rd_reg(2'h0);
      chk(d[0], 1'b0);
      wr_reg(2'h1, 16'h0001);
      repeat (2) @(negedge clk_sys);
      chk(irq, 1'b0);
      wr_reg(2'h2, 16'h0000);
      wr_reg(2'h0, 16'h0001);
      repeat (12) @(negedge clk_sys);
      chk(irq, 1'b0);
      rd_reg(2'h1);
      chk(d[0], 1'b1);
      wr_reg(2'h1, 16'h0001);
      // re-enable command while idle: enable pulses and clears, busy stays low
      wr_reg(2'h0, 16'h0011);
      repeat (12) @(negedge clk_sys);
      rd_reg(2'h0);
      chk(d[7:0], 8'h00);
      rd_reg(2'h1);
      chk(d[1:0], 2'h1);
      wr_reg(2'h1, 16'h0003);
   endtask
   // cpu holds a command during an eeprom write, then one that slips past its check is refused
   task test_refuse();
      @(posedge clk_sys) ee_active <= 1'b1;
      wr_reg(2'h0, 16'h0001);
      repeat (10) @(negedge clk_sys);
      rd_reg(2'h0);
      chk(d[0], 1'b0);
      @(posedge clk_sys) ee_active <= 1'b0;
      repeat (12) @(negedge clk_sys);
      rd_reg(2'h1);
      chk(d[1:0], 2'h1);
      wr_reg(2'h1, 16'h0003);
      wr_reg(2'h0, 16'h0001);
      @(posedge clk_sys) ee_active <= 1'b1;
      repeat (8) @(negedge clk_sys);
      rd_reg(2'h1);
      chk(d[1:0], 2'h2);
      @(posedge clk_sys) ee_active <= 1'b0;
      wr_reg(2'h1, 16'h0003);
   endtask
   // page erase, then fetches on both sides of the region split
   task test_erase();
      wr_reg(2'h3, 16'h2d80);
      wr_reg(2'h0, 16'h0003);
      for (int i = 0; i < 30 && flash_erase !== 1'b1; i++) @(negedge clk_sys);
      chk(flash_erase, 1'b1);
      chk(page_index, 7'h5b);
      repeat (3) @(negedge clk_sys);
      chk(rw_busy, 1'b1);
      rd_reg(2'h0);
      chk(d[0], 1'b1);
      chk(d[6], 1'b1);
      @(posedge clk_sys) fetch_addr <= 15'h47ff;
      repeat (3) @(negedge clk_sys);
      chk(link.fetch_block, 1'b1);
      @(posedge clk_sys) fetch_addr <= 15'h4800;
      repeat (3) @(negedge clk_sys);
      chk(link.fetch_block, 1'b0);
   endtask
   task test_write();
      reset_dut();
      wr_reg(2'h3, 16'h1500);
      wr_reg(2'h0, 16'h0005);
      for (int i = 0; i < 30 && flash_write !== 1'b1; i++) @(negedge clk_sys);
      chk(flash_write, 1'b1);
      chk(page_index, 7'h2a);
   endtask
   task wrap_up();
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      test_boot();
      test_fill_irq();
      test_refuse();
      test_erase();
      test_write();
      wrap_up();
   end
   // the run needs a few hundred cycles; cut a hang well short of 100k
   initial begin
      #40000;
      n_errors++;
      wrap_up();
   end
endmodule // tb
